// >>> logic/iptc_pkg.sv
// package: constants and carrier types for the input conditioner
package iptc_pkg;
  localparam int IPTC_NUM_DIG = 4;
  localparam int IPTC_NUM_ANA = 2;
  localparam int IPTC_ADC_W = 10;
  // ten-bit percentage scale: 0 is 0 %, 1023 is 100 %
  localparam logic [9:0] IPTC_PCT_FULL = 10'h3FF;
  // 2.5 V on a 0..5 V ten-bit converter is half scale
  localparam logic [9:0] IPTC_THRESH_CODE = 10'h200;
  // clock and tick timing
  localparam int IPTC_CLK_HZ = 20000000;
  localparam int IPTC_TICK_MS = 10;
  localparam int IPTC_TICK_CYC = IPTC_CLK_HZ / 1000 * IPTC_TICK_MS;
  localparam int IPTC_DEB_MAX_MS = 9990;
  localparam logic [9:0] IPTC_DEB_MAX_STEPS = 10'(IPTC_DEB_MAX_MS / IPTC_TICK_MS);
  // wishbone register word addresses (byte address = 4 * index)
  localparam logic [7:0] IPTC_REG_CTRL_IDX = 8'h00;
  localparam logic [7:0] IPTC_REG_DEB_IDX = 8'h01;
  localparam logic [7:0] IPTC_REG_VAR_IDX = 8'h02;
  localparam logic [7:0] IPTC_REG_ANA_IDX = 8'h03;
  localparam logic [7:0] IPTC_REG_STAT_IDX = 8'h04;
  localparam logic [7:0] IPTC_REG_RATE_IDX = 8'h05;
  // ctrl field layout: per input one byte at 8*i
  localparam int IPTC_CF_POL = 0;
  localparam int IPTC_CF_TOG = 1;
  localparam int IPTC_CF_TYPE_LO = 2;
  localparam int IPTC_CF_SHUT = 4;
  localparam int IPTC_CF_ADIG = 5;
  localparam logic [31:0] IPTC_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] IPTC_DEB_RESET = 32'h0000_0000;
  localparam logic [31:0] IPTC_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    IPTC_TYPE_DIGITAL = 2'b00,
    IPTC_TYPE_RPM = 2'b01,
    IPTC_TYPE_COUNTER = 2'b10
  } iptc_type_t;

  // configuration of one input, as carried between the bus and the channels
  typedef struct packed {
    logic active_low;
    logic toggle;
    iptc_type_t in_type;
    logic [9:0] deb_steps;
  } iptc_cfg_t;
endpackage

// >>> logic/iptc_channel.sv
// module: one debounced digital input channel
`timescale 1ns/1ps
module iptc_channel
  import iptc_pkg::*;
(
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // sync reset, active low
  input wire logic tick_in, // 10 ms tick pulse
  input wire logic level_in, // synchronised input level
  input wire iptc_cfg_t cfg_in, // polarity, mode, debounce
  input wire logic clear_in, // software write of false
  output logic var_out, // program variable
  output logic pulse_out // one cycle per accepted active edge
);
  logic stable;
  logic [9:0] cnt;
  logic var_q;
  logic pulse;
  logic next_stable;
  logic [9:0] next_cnt;
  logic next_var;
  logic next_pulse;
  logic active;

  // debounce, then polarity, then level or toggle interpretation
  always_comb begin
    next_stable = stable;
    next_cnt = cnt;
    next_pulse = 1'b0;
    if (level_in == stable) begin
      next_cnt = 10'h000; // change vanished, restart the wait
    end else if (cnt >= cfg_in.deb_steps) begin
      next_stable = level_in; // still changed after the interval
      next_cnt = 10'h000;
    end else if (tick_in) begin
      next_cnt = cnt + 10'h001; // interval counted in 10 ms steps
    end
    active = next_stable ^ cfg_in.active_low;
    next_var = var_q;
    if (cfg_in.toggle) begin
      if (active && (next_stable != stable)) begin
        next_var = ~var_q; // active edge flips the latch
        next_pulse = 1'b1;
      end else if (clear_in) begin
        next_var = 1'b0; // software clear only in toggle mode
      end
    end else begin
      next_var = active; // level mode tracks, writes ignored
      next_pulse = active && (next_stable != stable);
    end
  end

  // state registers, cleared on reset
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      stable <= 1'b0;
      cnt <= 10'h000;
      var_q <= 1'b0;
      pulse <= 1'b0;
    end else begin
      stable <= next_stable;
      cnt <= next_cnt;
      var_q <= next_var;
      pulse <= next_pulse;
    end
  end

  assign var_out = var_q;
  assign pulse_out = pulse;
endmodule

// >>> logic/iptc_top.sv
// module: input polarity/toggle conditioner with wishbone registers
`timescale 1ns/1ps
module iptc_top
  import iptc_pkg::*;
(
  input wire logic clk_in, // 20 MHz system clock
  input wire logic rst_n_in, // sync reset, active low
  input wire logic [IPTC_NUM_DIG-1:0] dig_in, // raw switch pins
  input wire logic [IPTC_NUM_ANA*IPTC_ADC_W-1:0] ana_code_in, // converter codes, same clock
  input wire logic [31:0] wb_adr_in, // wishbone byte address
  input wire logic [31:0] wb_dat_in, // wishbone write data
  input wire logic [3:0] wb_sel_in, // byte enables
  input wire logic wb_we_in, // write enable
  input wire logic wb_cyc_in, // cycle
  input wire logic wb_stb_in, // strobe
  output logic [31:0] wb_dat_out, // read data
  output logic wb_ack_out, // acknowledge
  output logic valve_enable_out // high while valve current paths may run
);
  logic [IPTC_NUM_DIG-1:0] sync1, sync2;
  logic [31:0] ctrl, deb, next_ctrl, next_deb;
  logic [31:0] rdat, next_rdat;
  logic ack, next_ack;
  // divider width follows the 10 ms cycle count, so the tick never wraps early
  localparam int TICK_W = $clog2(IPTC_TICK_CYC);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(IPTC_TICK_CYC - 1);
  localparam logic [TICK_W-1:0] TICK_STEP = TICK_W'(1);
  logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
  logic tick, next_tick;
  logic shutdown, next_shutdown;
  logic [IPTC_NUM_DIG-1:0] var_w, pulse_w, clr_w;
  logic [IPTC_NUM_DIG*8-1:0] rate_cnt, next_rate_cnt;
  logic [IPTC_NUM_ANA-1:0] ana_dig;
  logic [7:0] idx;
  logic wr;

  // decoding used by both write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  function automatic logic [31:0] bytemask(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    bytemask = (old & ~m) | (nw & m);
  endfunction

  assign idx = wb_adr_in[9:2];
  assign wr = wb_cyc_in && wb_stb_in && wb_we_in && !ack;

  //////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= dig_in;
      sync2 <= sync1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // 10 ms tick divider
  always_comb begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + TICK_STEP;
    if (tick_cnt == TICK_LAST) begin
      next_tick_cnt = '0;
      next_tick = 1'b1; // one pulse per 10 ms
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // channels; debounce steps clamp at the top of the range
  genvar g;
  generate
    for (g = 0; g < IPTC_NUM_DIG; g++) begin : g_ch
      iptc_cfg_t cfg;
      logic [7:0] raw_steps;
      logic [9:0] steps;
      assign raw_steps = deb[8*g +: 8];
      // limitation: an 8-bit field reaches 2550 ms; full 9990 ms range needs a wider map
      assign steps = ({2'b00, raw_steps} > IPTC_DEB_MAX_STEPS) ? IPTC_DEB_MAX_STEPS
                     : {2'b00, raw_steps};
      // one driver for the whole packed struct, fields never split across assigns
      assign cfg = '{
        active_low: ctrl[8*g + IPTC_CF_POL],
        toggle: ctrl[8*g + IPTC_CF_TOG],
        in_type: iptc_type_t'(ctrl[8*g + IPTC_CF_TYPE_LO +: 2]),
        deb_steps: steps
      };
      // write of zero to a variable bit is a clear request
      assign clr_w[g] = wr && hit(idx, IPTC_REG_VAR_IDX) && wb_sel_in[0] && !wb_dat_in[g];
      iptc_channel u_ch (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .tick_in(tick),
        .level_in(sync2[g]),
        .cfg_in(cfg),
        .clear_in(clr_w[g]),
        .var_out(var_w[g]),
        .pulse_out(pulse_w[g])
      );
    end
    // analog channels thresholded at half scale, inverted for active low
    for (g = 0; g < IPTC_NUM_ANA; g++) begin : g_ana
      assign ana_dig[g] = (ana_code_in[g*IPTC_ADC_W +: IPTC_ADC_W] > IPTC_THRESH_CODE)
                          ^ ctrl[8*g + IPTC_CF_ADIG];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // pulse counters for rpm and counter types; rpm internals kept minimal
  always_comb begin
    next_rate_cnt = rate_cnt;
    for (int i = 0; i < IPTC_NUM_DIG; i++) begin
      if (ctrl[8*i + IPTC_CF_TYPE_LO +: 2] == IPTC_TYPE_DIGITAL) begin
        next_rate_cnt[8*i +: 8] = 8'h00;
      end else if (pulse_w[i]) begin
        next_rate_cnt[8*i +: 8] = rate_cnt[8*i +: 8] + 8'h01; // measured_rotation_rate source
      end
    end
  end

  // counter registers; eight bits wrap, software reads the difference
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rate_cnt <= '0;
    end else begin
      rate_cnt <= next_rate_cnt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shutdown latch: once set only a reset (power cycle) clears it
  always_comb begin
    next_shutdown = shutdown;
    if (ctrl[IPTC_CF_SHUT] && var_w[0]) begin
      next_shutdown = 1'b1; // system_shutdown_input_mode on input 0
    end
  end

  // valve enable follows the latch a cycle early so the pin drops with it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      shutdown <= 1'b0;
      valve_enable_out <= 1'b0;
    end else begin
      shutdown <= next_shutdown;
      valve_enable_out <= !next_shutdown;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one-cycle ack, registered read data
  always_comb begin
    next_ctrl = ctrl;
    next_deb = deb;
    next_ack = wb_cyc_in && wb_stb_in && !ack;
    next_rdat = rdat;
    if (wr) begin
      if (hit(idx, IPTC_REG_CTRL_IDX)) begin
        next_ctrl = bytemask(ctrl, wb_dat_in, wb_sel_in);
      end else if (hit(idx, IPTC_REG_DEB_IDX)) begin
        next_deb = bytemask(deb, wb_dat_in, wb_sel_in);
      end
    end
    if (wb_cyc_in && wb_stb_in && !wb_we_in && !ack) begin
      if (hit(idx, IPTC_REG_CTRL_IDX)) begin
        next_rdat = ctrl;
      end else if (hit(idx, IPTC_REG_DEB_IDX)) begin
        next_rdat = deb;
      end else if (hit(idx, IPTC_REG_VAR_IDX)) begin
        next_rdat = {28'h000_0000, var_w};
      end else if (hit(idx, IPTC_REG_ANA_IDX)) begin
        // ten-bit percent codes, 1023 steps, finer than a tenth percent
        next_rdat = {6'h00, ana_code_in[IPTC_ADC_W +: IPTC_ADC_W], 6'h00, ana_code_in[0 +: IPTC_ADC_W]};
      end else if (hit(idx, IPTC_REG_STAT_IDX)) begin
        next_rdat = {27'h000_0000, shutdown, 2'b00, ana_dig};
      end else if (hit(idx, IPTC_REG_RATE_IDX)) begin
        next_rdat = rate_cnt;
      end else begin
        next_rdat = IPTC_UNMAPPED;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl <= IPTC_CTRL_RESET;
      deb <= IPTC_DEB_RESET;
      ack <= 1'b0;
      rdat <= IPTC_UNMAPPED;
    end else begin
      ctrl <= next_ctrl;
      deb <= next_deb;
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  assign wb_ack_out = ack;
  assign wb_dat_out = rdat;
endmodule

// >>> testbench/iptc_switch_model.sv
// switch model: drives the raw pins, with optional contact chatter
`timescale 1ns/1ps
module iptc_switch_model (
  input wire logic clk_in, // clock
  input wire logic [3:0] want_in, // settled levels
  input wire logic bounce_in, // chatter on change
  output logic [3:0] pin_out // raw pins
);
  logic [3:0] prev = 4'h0;
  logic [3:0] mask = 4'h0;
  logic [2:0] cnt = 3'h0;
  // a real contact never lands clean, so moved bits chatter a while
  always @(posedge clk_in) begin
    prev <= want_in;
    if (bounce_in && want_in != prev) begin
      mask <= want_in ^ prev;
      cnt <= 3'h7;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
  assign pin_out = want_in ^ (cnt[0] ? mask : 4'h0);
endmodule

// >>> testbench/iptc_top_asserts.sv
// checker: bus, reset and shutdown relations at the top ports
`timescale 1ns/1ps
module iptc_top_asserts
  import iptc_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic [IPTC_NUM_DIG-1:0] dig_in, // pins
  input wire logic [IPTC_NUM_ANA*IPTC_ADC_W-1:0] ana_code_in, // codes
  input wire logic [31:0] wb_adr_in, // address
  input wire logic [31:0] wb_dat_in, // wdata
  input wire logic [3:0] wb_sel_in, // lanes
  input wire logic wb_we_in, // write
  input wire logic wb_cyc_in, // cycle
  input wire logic wb_stb_in, // strobe
  input wire logic [31:0] wb_dat_out, // rdata
  input wire logic wb_ack_out, // ack
  input wire logic valve_enable_out // valves
);
  logic req, rd_ana, rd_bad;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // decoded requests, so each answer can be tied to its cause
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign rd_ana = req && !wb_we_in && wb_adr_in[9:2] == IPTC_REG_ANA_IDX;
  assign rd_bad = req && !wb_we_in && wb_adr_in[9:2] > IPTC_REG_RATE_IDX;
  //////////////////////////////////////////////////////////////
  chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held too long");
  chk_ack_prompt: assert property (req |=> wb_ack_out) else $error("ack missing");
  chk_ack_cause: assert property (wb_ack_out |-> $past(req)) else $error("ack without request");
  chk_dat_hold: assert property ($changed(wb_dat_out) |-> wb_ack_out && !$past(wb_we_in))
    else $error("read data moved outside a read");
  chk_reset_quiet: assert property ($rose(rst_n_in)
    |-> !wb_ack_out && !valve_enable_out && wb_dat_out == 32'h0000_0000) else $error("outputs not cleared");
  chk_valve_up: assert property ($rose(rst_n_in) |=> valve_enable_out) else $error("valves not enabled");
  chk_valve_latch: assert property ($fell(valve_enable_out)
    |=> !valve_enable_out [*8]) else $error("valves came back");
  chk_ana_read: assert property (wb_ack_out && $past(rd_ana)
    |-> wb_dat_out[9:0] == $past(ana_code_in[9:0])) else $error("analog code wrong");
  chk_unmapped_zero: assert property (wb_ack_out && $past(rd_bad) |-> wb_dat_out == 32'h0000_0000)
    else $error("unmapped read not zero");
endmodule
bind iptc_top iptc_top_asserts u_chk (.clk_in, .rst_n_in, .dig_in, .ana_code_in, .wb_adr_in, .wb_dat_in,
  .wb_sel_in, .wb_we_in, .wb_cyc_in, .wb_stb_in, .wb_dat_out, .wb_ack_out, .valve_enable_out);

// >>> testbench/tb.sv
// testbench: register access, input conditioning and shutdown
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
  import iptc_pkg::*;
  logic clk_in, rst_n_in, wb_we_in, wb_cyc_in, wb_stb_in, wb_ack_out, valve_enable_out, bounce;
  logic [3:0] dig_in, want, wb_sel_in;
  logic [19:0] ana_code_in;
  logic [31:0] wb_adr_in, wb_dat_in, wb_dat_out, d, r0;
  iptc_type_t tl [3] = '{IPTC_TYPE_RPM, IPTC_TYPE_COUNTER, IPTC_TYPE_DIGITAL};
  int miscompares = 0;
  int n_tests = 0;
  iptc_top u_dut (.clk_in, .rst_n_in, .dig_in, .ana_code_in, .wb_adr_in, .wb_dat_in, .wb_sel_in,
    .wb_we_in, .wb_cyc_in, .wb_stb_in, .wb_dat_out, .wb_ack_out, .valve_enable_out);
  iptc_switch_model u_sw (.clk_in, .want_in(want), .bounce_in(bounce), .pin_out(dig_in));
  // 20 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  //////////////////////////////////////////////////////////////
  // one classic cycle; waits for ack (watchdog ends a hang), read data lands in d
  task automatic xfer(input logic [7:0] idx, input logic we, input logic [31:0] wd);
    @(posedge clk_in);
    wb_adr_in <= {22'h0, idx, 2'b00};
    wb_we_in <= we;
    wb_dat_in <= wd;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (wb_ack_out !== 1'b1);
    d = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    xfer(idx, 1'b0, 32'h0000_0000);
    `CHK(d, exp)
  endtask
  // sync, debounce at zero steps and variable update all fit well inside the wait
  task automatic pins(input logic [3:0] v);
    @(posedge clk_in);
    want <= v;
    repeat (12) @(posedge clk_in);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #(50 * 40000);
    miscompares++;
    finish_test();
  end
  //////////////////////////////////////////////////////////////
  initial begin
    {rst_n_in, wb_we_in, wb_cyc_in, wb_stb_in, bounce, want} = '0;
    {wb_adr_in, wb_dat_in} = '0;
    wb_sel_in = 4'hf;
    ana_code_in = {10'h200, IPTC_PCT_FULL};
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rdc(IPTC_REG_CTRL_IDX, IPTC_CTRL_RESET);
    rdc(IPTC_REG_DEB_IDX, IPTC_DEB_RESET);
    rdc(IPTC_REG_VAR_IDX, 32'h0000_0000);
    rdc(8'h3f, IPTC_UNMAPPED);
    pins(4'h1);
    rdc(IPTC_REG_VAR_IDX, 32'h0000_0001);
    xfer(IPTC_REG_VAR_IDX, 1'b1, 32'h0000_0000);
    rdc(IPTC_REG_VAR_IDX, 32'h0000_0001);
    pins(4'h4);
    rdc(IPTC_REG_VAR_IDX, 32'h0000_0004);
    // input 0 level active low, 1 toggle high, 2 toggle low
    xfer(IPTC_REG_CTRL_IDX, 1'b1, 32'h0003_0201);
    xfer(IPTC_REG_VAR_IDX, 1'b1, 32'h0000_0000);
    rdc(IPTC_REG_VAR_IDX, 32'h0000_0001);
    pins(4'h6);
    rdc(IPTC_REG_VAR_IDX, 32'h0000_0003);
    pins(4'h4);
    rdc(IPTC_REG_VAR_IDX, 32'h0000_0003);
    pins(4'h0);
    rdc(IPTC_REG_VAR_IDX, 32'h0000_0007);
    pins(4'h2);
    rdc(IPTC_REG_VAR_IDX, 32'h0000_0005);
    pins(4'h6);
    rdc(IPTC_REG_VAR_IDX, 32'h0000_0005);
    // edge count on input 3 for every type; digital zeroes it
    for (int i = 0; i < 3; i++) begin
      xfer(IPTC_REG_CTRL_IDX, 1'b1, {4'h0, tl[i], 2'b00, 24'h03_0201});
      xfer(IPTC_REG_RATE_IDX, 1'b0, 32'h0000_0000);
      r0 = d;
      pins(4'h8);
      pins(4'h0);
      pins(4'h8);
      pins(4'h0);
      xfer(IPTC_REG_RATE_IDX, 1'b0, 32'h0000_0000);
      `CHK(d[31:24], (tl[i] == IPTC_TYPE_DIGITAL) ? 8'h00 : r0[31:24] + 8'h02)
    end
    xfer(IPTC_REG_DEB_IDX, 1'b1, 32'h0200_ff00);
    rdc(IPTC_REG_DEB_IDX, 32'h0200_ff00);
    // a chattering pulse far shorter than two ticks must be ignored
    bounce <= 1'b1;
    pins(4'h8);
    xfer(IPTC_REG_VAR_IDX, 1'b0, 32'h0000_0000);
    `CHK(d[3], 1'b0)
    pins(4'h0);
    bounce <= 1'b0;
    xfer(IPTC_REG_VAR_IDX, 1'b0, 32'h0000_0000);
    `CHK(d[3], 1'b0)
    xfer(IPTC_REG_ANA_IDX, 1'b0, 32'h0000_0000);
    `CHK(d[9:0], IPTC_PCT_FULL)
    `CHK(d[25:16], 10'h200)
    xfer(IPTC_REG_STAT_IDX, 1'b0, 32'h0000_0000);
    `CHK(d[1:0], 2'b01)
    xfer(IPTC_REG_CTRL_IDX, 1'b1, 32'h0003_2201);
    xfer(IPTC_REG_STAT_IDX, 1'b0, 32'h0000_0000);
    `CHK(d[1:0], 2'b11)
    // input 0 inactive before shutdown mode is armed, so no stale true trips it
    xfer(IPTC_REG_CTRL_IDX, 1'b1, 32'h0003_2200);
    xfer(IPTC_REG_CTRL_IDX, 1'b1, 32'h0003_2210);
    xfer(IPTC_REG_STAT_IDX, 1'b0, 32'h0000_0000);
    `CHK(d[4], 1'b0)
    `CHK(valve_enable_out, 1'b1)
    pins(4'h1);
    `CHK(valve_enable_out, 1'b0)
    xfer(IPTC_REG_STAT_IDX, 1'b0, 32'h0000_0000);
    `CHK(d[4], 1'b1)
    pins(4'h0);
    `CHK(valve_enable_out, 1'b0)
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    `CHK(valve_enable_out, 1'b1)
    rdc(IPTC_REG_VAR_IDX, 32'h0000_0000);
    finish_test();
  end
endmodule
